//--- core/hwd_params.svh
// Constants for the two-channel handwheel decoder: register map, resets, widths.
// Assumes a 32-bit APB register bus and a 25 MHz core clock.
`ifndef HWD_PARAMS_SVH
`define HWD_PARAMS_SVH
`define HWD_ADDR_W 8
`define HWD_OFS_CTRL1 8'h00
`define HWD_OFS_CTRL2 8'h04
`define HWD_OFS_INVERT 8'h08
`define HWD_OFS_FORMAT 8'h0C
`define HWD_OFS_COUNT1 8'h10
`define HWD_OFS_COUNT2 8'h14
`define HWD_OFS_LATCH1 8'h18
`define HWD_OFS_LATCH2 8'h1C
`define HWD_CTRL_W 4
`define HWD_CTRL_RST 4'h7
`define HWD_INVERT_RST 2'h0
`define HWD_FORMAT_RST 4'h0
`define HWD_FMT_W 2
`define HWD_FMT_PWM_PFM 2'h2
`define HWD_FMT_DAC_PFM 2'h3
`define HWD_CNT_W 24
`endif

//--- core/hwd_pkg.sv
// Types shared by the handwheel decoder.
// Assumes hwd_params.svh for the numeric constants.
package hwd_pkg;
  typedef enum logic [3:0] {
    HWD_PD_CW = 4'b0000,
    HWD_X1_CW = 4'b0001,
    HWD_X2_CW = 4'b0010,
    HWD_X4_CW = 4'b0011,
    HWD_PD_CCW = 4'b0100,
    HWD_X1_CCW = 4'b0101,
    HWD_X2_CCW = 4'b0110,
    HWD_X4_CCW = 4'b0111,
    HWD_LOOPBACK = 4'b1000,
    HWD_TIMER = 4'b1100
  } hwd_mode_t;
endpackage

//--- core/hwd_decoder.sv
// Two-channel handwheel decoder with APB register slave.
// Assumes encoder pins are asynchronous and the PFM signals come from logic on clk.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "hwd_params.svh"

// Functional notes
// - Each channel has its own 4-bit decode-mode register that resets to 7.
// - Modes 0-3 are pulse-dir and x1/x2/x4 CW, 4-7 the same CCW, 8 loopback, 12 timer.
// - Quadrature x1, x2 and x4 give one, two and four counts per input cycle.
// - CW or CCW only chooses which motion direction counts up; the other counts down.
// - Pulse-dir decode counts pulses on A with the sign taken from B.
// - Mode 8 decodes the matching PFM channel's pulse and direction internally.
// - In loopback the count direction follows the PFM direction automatically.
// - Mode 12 clears a timer on the excitation pulse and latches it on a rise of A.
// - Direction output is low for positive when invert is 0 and high when it is 1.
// - Invert acts only when the output format is 2 or 3 (PFM on output C).
// - Channel 2 is identical to channel 1 with its own register, pins and PFM source.
// - Format 2 is PWM on A/B with PFM on C; format 3 is DAC on A/B with PFM on C.
module hwd_decoder import hwd_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [`HWD_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic handwheel1_input_a,
  input wire logic handwheel1_input_b,
  input wire logic handwheel2_input_a,
  input wire logic handwheel2_input_b,
  input wire logic excitation_pulse_output1,
  input wire logic excitation_pulse_output2,
  input wire logic pfm1_dir_cmd,
  input wire logic pfm2_dir_cmd,
  output logic pfm1_dir_out,
  output logic pfm2_dir_out
);
  logic [`HWD_CTRL_W-1:0] handwheel1_decode_control;
  logic [`HWD_CTRL_W-1:0] handwheel2_decode_control;
  logic [1:0] pfm_direction_invert;
  logic [2*`HWD_FMT_W-1:0] output_format_select;
  logic [`HWD_CNT_W-1:0] count [2];
  logic [`HWD_CNT_W-1:0] latch [2];
  logic [1:0] dir_out;
  logic [1:0] pin_a;
  logic [1:0] pin_b;
  logic [1:0] pfm_pulse;
  logic [1:0] pfm_dir;
  logic [`HWD_CTRL_W-1:0] mode [2];
  logic wr_access;
  logic setup;
  logic mapped;

  assign pin_a = {handwheel2_input_a, handwheel1_input_a};
  assign pin_b = {handwheel2_input_b, handwheel1_input_b};
  assign pfm_pulse = {excitation_pulse_output2, excitation_pulse_output1};
  assign pfm_dir = {pfm2_dir_cmd, pfm1_dir_cmd};
  assign mode[0] = handwheel1_decode_control;
  assign mode[1] = handwheel2_decode_control;
  assign pfm1_dir_out = dir_out[0];
  assign pfm2_dir_out = dir_out[1];

  // Zero wait states: read data is captured in setup, so it is a flop at access
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign mapped = (paddr == `HWD_OFS_CTRL1) || (paddr == `HWD_OFS_CTRL2)
    || (paddr == `HWD_OFS_INVERT) || (paddr == `HWD_OFS_FORMAT)
    || (paddr == `HWD_OFS_COUNT1) || (paddr == `HWD_OFS_COUNT2)
    || (paddr == `HWD_OFS_LATCH1) || (paddr == `HWD_OFS_LATCH2);
  assign pslverr = psel && penable && !mapped;

  // Register writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      handwheel1_decode_control <= `HWD_CTRL_RST;
      handwheel2_decode_control <= `HWD_CTRL_RST;
      pfm_direction_invert <= `HWD_INVERT_RST;
      output_format_select <= `HWD_FORMAT_RST;
    end else if (wr_access) begin
      if (paddr == `HWD_OFS_CTRL1) begin
        handwheel1_decode_control <= pwdata[`HWD_CTRL_W-1:0];
      end else if (paddr == `HWD_OFS_CTRL2) begin
        handwheel2_decode_control <= pwdata[`HWD_CTRL_W-1:0];
      end else if (paddr == `HWD_OFS_INVERT) begin
        pfm_direction_invert <= pwdata[1:0];
      end else if (paddr == `HWD_OFS_FORMAT) begin
        output_format_select <= pwdata[2*`HWD_FMT_W-1:0];
      end
    end
  end

  // Read data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      if (paddr == `HWD_OFS_CTRL1) begin
        prdata <= {28'h000_0000, handwheel1_decode_control};
      end else if (paddr == `HWD_OFS_CTRL2) begin
        prdata <= {28'h000_0000, handwheel2_decode_control};
      end else if (paddr == `HWD_OFS_INVERT) begin
        prdata <= {30'h0000_0000, pfm_direction_invert};
      end else if (paddr == `HWD_OFS_FORMAT) begin
        prdata <= {28'h000_0000, output_format_select};
      end else if (paddr == `HWD_OFS_COUNT1) begin
        prdata <= {8'h00, count[0]};
      end else if (paddr == `HWD_OFS_COUNT2) begin
        prdata <= {8'h00, count[1]};
      end else if (paddr == `HWD_OFS_LATCH1) begin
        prdata <= {8'h00, latch[0]};
      end else if (paddr == `HWD_OFS_LATCH2) begin
        prdata <= {8'h00, latch[1]};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  property p_ctrl_write;
    @(posedge clk) disable iff (!arst_n)
    (wr_access && paddr == `HWD_OFS_CTRL1)
      |=> handwheel1_decode_control == $past(pwdata[`HWD_CTRL_W-1:0]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("mode write lost");

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [2:0] sync_a;
      logic [2:0] sync_b;
      logic fa;
      logic fb;
      logic pa;
      logic pb;
      logic pulse_prev;
      logic [1:0] fmt;
      logic ccw;
      logic pd_step;
      logic quad_step;
      logic fwd;
      logic step;
      logic up;
      logic pfm_rise;
      logic a_rise;

      // Three-stage sync; a change counts once stages two and three agree
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          sync_a <= 3'h0;
          sync_b <= 3'h0;
          fa <= 1'b0;
          fb <= 1'b0;
          pa <= 1'b0;
          pb <= 1'b0;
          pulse_prev <= 1'b0;
        end else begin
          sync_a <= {sync_a[1:0], pin_a[ch]};
          sync_b <= {sync_b[1:0], pin_b[ch]};
          fa <= (sync_a[1] == sync_a[2]) ? sync_a[2] : fa;
          fb <= (sync_b[1] == sync_b[2]) ? sync_b[2] : fb;
          pa <= fa;
          pb <= fb;
          pulse_prev <= pfm_pulse[ch];
        end
      end

      assign a_rise = fa && !pa;
      assign pfm_rise = pfm_pulse[ch] && !pulse_prev;
      assign ccw = mode[ch][2];
      // Forward when A leads B; a double change is not a legal step
      assign fwd = fa ^ pb;
      assign pd_step = a_rise;
      assign quad_step = ((fa ^ pa) ^ (fb ^ pb));

      always_comb begin
        step = 1'b0;
        up = 1'b0;
        case (hwd_mode_t'(mode[ch]))
          HWD_PD_CW, HWD_PD_CCW: begin
            step = pd_step;
            up = fb ^ ccw;
          end
          HWD_X1_CW, HWD_X1_CCW: begin
            step = quad_step && (fa ^ pa) && !fb;
            up = fwd ^ ccw;
          end
          HWD_X2_CW, HWD_X2_CCW: begin
            step = quad_step && (fa ^ pa);
            up = fwd ^ ccw;
          end
          HWD_X4_CW, HWD_X4_CCW: begin
            step = quad_step;
            up = fwd ^ ccw;
          end
          HWD_LOOPBACK: begin
            step = pfm_rise;
            up = pfm_dir[ch];
          end
          default: begin
            step = 1'b0;
            up = 1'b0;
          end
        endcase
      end

      // Counter; in timer mode it runs as the transducer timer
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          count[ch] <= '0;
        end else if (mode[ch] == HWD_TIMER) begin
          if (pfm_rise) begin
            count[ch] <= '0;
          end else begin
            count[ch] <= count[ch] + `HWD_CNT_W'(1);
          end
        end else if (step) begin
          count[ch] <= up ? count[ch] + `HWD_CNT_W'(1) : count[ch] - `HWD_CNT_W'(1);
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          latch[ch] <= '0;
        end else if (mode[ch] == HWD_TIMER && a_rise) begin
          latch[ch] <= count[ch];
        end
      end

      // Direction output; invert honoured only while output C carries PFM
      assign fmt = output_format_select[ch*`HWD_FMT_W +: `HWD_FMT_W];
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          dir_out[ch] <= 1'b0;
        end else if (fmt == `HWD_FMT_PWM_PFM || fmt == `HWD_FMT_DAC_PFM) begin
          dir_out[ch] <= pfm_direction_invert[ch] ? pfm_dir[ch] : !pfm_dir[ch];
        end else begin
          dir_out[ch] <= !pfm_dir[ch];
        end
      end

      sequence s_fwd_edge;
        mode[ch] == HWD_X4_CW && quad_step && fwd && !ccw;
      endsequence

      property p_x4_up;
        @(posedge clk) disable iff (!arst_n)
        s_fwd_edge |=> count[ch] == $past(count[ch]) + 24'h00_0001;
      endproperty
      a_x4_up: assert property (p_x4_up) else $error("x4 step not counted up");

      property p_ccw_down;
        @(posedge clk) disable iff (!arst_n)
        (mode[ch] == HWD_X4_CCW && quad_step && fwd)
          |=> count[ch] == $past(count[ch]) - 24'h00_0001;
      endproperty
      a_ccw_down: assert property (p_ccw_down) else $error("ccw did not count down");

      property p_x1_b_only;
        @(posedge clk) disable iff (!arst_n)
        (mode[ch] == HWD_X1_CW && (fb ^ pb) && !(fa ^ pa)) |=> $stable(count[ch]);
      endproperty
      a_x1_b_only: assert property (p_x1_b_only) else $error("x1 counted on B");

      property p_double_change;
        @(posedge clk) disable iff (!arst_n)
        (mode[ch] == HWD_X4_CW && (fa ^ pa) && (fb ^ pb)) |=> $stable(count[ch]);
      endproperty
      a_double_change: assert property (p_double_change) else $error("bad step counted");

      property p_pd_count;
        @(posedge clk) disable iff (!arst_n)
        (mode[ch] == HWD_PD_CW && a_rise && fb) |=> count[ch] == $past(count[ch]) + 24'h00_0001;
      endproperty
      a_pd_count: assert property (p_pd_count) else $error("pulse not counted");

      property p_loopback;
        @(posedge clk) disable iff (!arst_n)
        (mode[ch] == HWD_LOOPBACK && pfm_rise && !pfm_dir[ch])
          |=> count[ch] == $past(count[ch]) - 24'h00_0001;
      endproperty
      a_loopback: assert property (p_loopback) else $error("loopback miscounted");

      sequence s_excite;
        mode[ch] == HWD_TIMER && pfm_rise;
      endsequence

      property p_timer_clear;
        @(posedge clk) disable iff (!arst_n)
        s_excite ##1 (mode[ch] == HWD_TIMER && !pfm_rise) |=> count[ch] == 24'h00_0001;
      endproperty
      a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");

      property p_dir_out;
        @(posedge clk) disable iff (!arst_n)
        (fmt == `HWD_FMT_DAC_PFM && pfm_dir[ch])
          |=> dir_out[ch] == $past(pfm_direction_invert[ch]);
      endproperty
      a_dir_out: assert property (p_dir_out) else $error("direction polarity wrong");
    end
  endgenerate
endmodule // hwd_decoder

//--- testbench/hwd_wheel_model.sv
// Behavioural handwheel source driving one channel's A and B pins.
// Assumes the decoder needs a few clk cycles per pin state.
`timescale 1ns/1ps
module hwd_wheel_model (
  input wire logic clk,
  output logic a,
  output logic b
);
  int ph = 0;
  initial begin
    a = 1'b0;
    b = 1'b0;
  end
  // One quadrature state step; forward runs 00,10,11,01
  task automatic quad(input int fwd);
    ph = fwd != 0 ? (ph + 1) % 4 : (ph + 3) % 4;
    @(posedge clk);
    a <= (ph == 1 || ph == 2);
    b <= (ph >= 2);
    repeat (6) @(posedge clk);
  endtask
  // Both pins at once: only used to provoke a rejected step
  task automatic jump();
    ph = (ph + 2) % 4;
    @(posedge clk);
    a <= ~a;
    b <= ~b;
    repeat (6) @(posedge clk);
  endtask
  // Sign set up on B well before the pulse on A
  task automatic pulse(input int fwd);
    @(posedge clk);
    b <= fwd[0];
    repeat (6) @(posedge clk);
    a <= 1'b1;
    repeat (6) @(posedge clk);
    a <= 1'b0;
    b <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule // hwd_wheel_model

//--- testbench/tb_handwheel_encoder_decoder.sv
// Self-checking bench for the handwheel decoder, APB master and count model.
// Assumes hwd_decoder, its package and hwd_wheel_model are compiled first.
`timescale 1ns/1ps
`include "hwd_params.svh"
module tb_handwheel_encoder_decoder import hwd_pkg::*; ();
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, a1, b1, a2, b2;
  logic [1:0] excv = 2'h0;
  logic [1:0] cmdv = 2'h0;
  logic [1:0] doutv;
  int failures = 0;
  int n_compared = 0;
  int seed = 32'h0740_634b;
  int cnt [2] = '{0, 0};

  always #20 clk = ~clk;

  hwd_decoder u_dut (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .handwheel1_input_a(a1),
    .handwheel1_input_b(b1), .handwheel2_input_a(a2), .handwheel2_input_b(b2),
    .excitation_pulse_output1(excv[0]), .excitation_pulse_output2(excv[1]),
    .pfm1_dir_cmd(cmdv[0]), .pfm2_dir_cmd(cmdv[1]), .pfm1_dir_out(doutv[0]),
    .pfm2_dir_out(doutv[1]));
  hwd_wheel_model u_w1 (.clk(clk), .a(a1), .b(b1));
  hwd_wheel_model u_w2 (.clk(clk), .a(a2), .b(b2));

  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Zero-wait slave, but the wait stays bounded in case pready never comes
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic move(input int ch, input int fwd, input int pd);
    if (pd != 0 && ch == 0)
      u_w1.pulse(fwd);
    else if (pd != 0)
      u_w2.pulse(fwd);
    else if (ch == 0)
      u_w1.quad(fwd);
    else
      u_w2.quad(fwd);
  endtask

  task automatic exc(input int ch, input logic d);
    @(posedge clk);
    excv[ch] <= 1'b1;
    cmdv[ch] <= d;
    @(posedge clk);
    excv[ch] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic chk_cnt(input int ch);
    apb(1'b0, `HWD_OFS_COUNT1 + 8'(4 * ch), 32'h0000_0000);
    cmp("count", 32'(cnt[ch] & 32'h00FF_FFFF), rd);
  endtask

  initial begin
    int m, k, s, n, d;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    apb(1'b0, `HWD_OFS_CTRL1, 32'h0);
    cmp("ctrl1", 32'h7, rd);
    apb(1'b0, `HWD_OFS_CTRL2, 32'h0);
    cmp("ctrl2", 32'h7, rd);
    apb(1'b0, `HWD_OFS_INVERT, 32'h0);
    cmp("invert", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    cmp("pslverr", 32'h1, 32'(err));
    for (int ch = 0; ch < 2; ch++) begin
      for (m = 0; m < 8; m++) begin
        apb(1'b1, 8'(4 * ch), ($random(seed) & 32'hFFFF_FFF0) | 32'(m));
        apb(1'b0, 8'(4 * ch), 32'h0);
        cmp("ctrl", 32'(m), rd);
        k = (m % 4 == 1) ? 1 : (m % 4 == 2) ? 2 : 4;
        s = (m >= 4) ? -1 : 1;
        for (d = 1; d >= 0; d--) begin
          repeat (4) move(ch, d, int'(m % 4 == 0));
          cnt[ch] += (d != 0) ? k * s : -k * s;
          repeat (4) @(posedge clk);
          chk_cnt(ch);
        end
      end
      // Rejected double steps, then an unused code that must hold
      apb(1'b1, 8'(4 * ch), 32'(HWD_X4_CW));
      if (ch == 0) u_w1.jump();
      else u_w2.jump();
      if (ch == 0) u_w1.jump();
      else u_w2.jump();
      apb(1'b1, 8'(4 * ch), 32'h0000_0009);
      repeat (4) move(ch, 1, 0);
      chk_cnt(ch);
      // Loopback ignores the pins and follows the PFM sign
      apb(1'b1, 8'(4 * ch), 32'(HWD_LOOPBACK));
      for (n = 0; n < 6; n++) begin
        d = $random(seed);
        exc(ch, d[0]);
        cnt[ch] += d[0] ? 1 : -1;
      end
      repeat (4) move(ch, 1, 0);
      chk_cnt(ch);
      apb(1'b1, 8'(4 * ch), 32'(HWD_TIMER));
      n = 5 + {$random(seed)} % 20;
      exc(ch, 1'b0);
      repeat (n) @(posedge clk);
      move(ch, 1, 0);
      apb(1'b0, `HWD_OFS_LATCH1 + 8'(4 * ch), 32'h0);
      d = int'(rd) - n;
      // Synchroniser latency is only loosely fixed, so a window is checked
      cmp("latch", 32'h1, 32'(d >= 4 && d <= 12));
      move(ch, 0, 0);
    end
    for (m = 0; m < 8; m++) begin
      apb(1'b1, `HWD_OFS_FORMAT, 32'((m % 4) * 5));
      apb(1'b1, `HWD_OFS_INVERT, 32'((m / 4) * 3));
      repeat (2) begin
        cmdv <= 2'($random(seed));
        repeat (3) @(posedge clk);
        k = (m % 4 >= 2 && m >= 4) ? 0 : 3;
        cmp("dir_out", 32'(cmdv ^ 2'(k)), 32'(doutv));
      end
    end
    print_verdict();
  end
endmodule // tb_handwheel_encoder_decoder
